// [src/fcsm_host.sv]
/*
  Flash command host: turns register orders into flash bus cycles,
  performs reads, and tracks the flash's mode and busy state.
  Assumes a NOR flash on the pins with inputs synchronous to i_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module fcsm_host #(
  parameter int ADDR_W = 21,
  parameter int BUSY_TIMEOUT = fcsm_pkg::BUSY_TIMEOUT_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic [ADDR_W-1:0] o_flash_addr,
  output logic [15:0] o_dq_out,
  output logic o_dq_oe,
  input wire logic [15:0] i_dq_in,
  output logic o_chip_enable_n,
  output logic o_write_enable_n,
  output logic o_output_enable_n,
  output logic o_byte_width_select_n,
  output logic o_hw_reset_n,
  input wire logic i_ready_busy_n
);

  typedef enum logic [2:0] {
    FCSM_S_IDLE,
    FCSM_S_SETUP,
    FCSM_S_STROBE,
    FCSM_S_HOLD,
    FCSM_S_READ,
    FCSM_S_BUSY,
    FCSM_S_HRST
  } fcsm_state_t;

  fcsm_state_t state_reg;
  fcsm_pkg::fcsm_req_t req;
  fcsm_pkg::fcsm_cycle_t cyc;
  logic [2:0] len;
  logic [2:0] idx_reg;
  logic [15:0] cnt_reg;
  logic [20:0] tgt_addr;
  logic [15:0] tgt_data;
  logic byte_mode;
  logic start;
  logic rd_go;
  logic [2:0] op_raw;
  fcsm_pkg::fcsm_op_t op;
  logic [15:0] rdata_reg;
  logic ident_reg;
  logic fast_reg;
  logic serial_reg;
  logic timeout_reg;
  logic err_reg;
  logic [31:0] status;

  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
  assign op = fcsm_pkg::fcsm_op_t'(op_raw);

  function automatic logic cnt_done(input logic [15:0] c, input int n);
    cnt_done = (c >= 16'(n - 1));
  endfunction : cnt_done

  fcsm_regs u_regs (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_req(req),
    .i_status(status),
    .i_rdata(rdata_reg),
    .o_rdata(o_rdata),
    .o_addr(tgt_addr),
    .o_data(tgt_data),
    .o_byte_mode(byte_mode),
    .o_start(start),
    .o_op(op_raw),
    .o_read(rd_go)
  );

  fcsm_seq_rom u_rom (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_op(op),
    .i_idx(idx_reg),
    .i_tgt_addr(tgt_addr),
    .i_tgt_data(tgt_data),
    .o_cycle(cyc),
    .o_len(len)
  );

  // ---------------------------------------------------------------
  // Status word
  // ---------------------------------------------------------------
  assign status = {24'h0, err_reg, timeout_reg, serial_reg, fast_reg,
                   ident_reg, !i_ready_busy_n,
                   state_reg != FCSM_S_IDLE, 1'b0};

  // ---------------------------------------------------------------
  // Bus cycle sequencer
  // ---------------------------------------------------------------
  // A write cycle: setup with address, strobe both enables low so the
  // flash latches address on the common fall and data on the common
  // rise, then a hold cycle.  Keeping them together avoids any doubt
  // about which edge is earlier or later.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_reg <= FCSM_S_HRST;
      idx_reg <= 3'h0;
      cnt_reg <= 16'h0000;
    end
    else
      unique case (state_reg)
        FCSM_S_IDLE:
        begin
          idx_reg <= 3'h0;
          cnt_reg <= 16'h0000;
          if (rd_go)
            state_reg <= FCSM_S_READ;
          else if (start)
            state_reg <= FCSM_S_SETUP;
        end
        FCSM_S_SETUP:
          state_reg <= FCSM_S_STROBE;
        FCSM_S_STROBE:
        begin
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_done(cnt_reg, fcsm_pkg::T_STROBE_CYC))
          begin
            cnt_reg <= 16'h0000;
            // Step here: the table output lags its index by one clock.
            idx_reg <= idx_reg + 3'h1;
            state_reg <= FCSM_S_HOLD;
          end
        end
        FCSM_S_HOLD:
        begin
          if (idx_reg < len)
            state_reg <= FCSM_S_SETUP;
          else if (op == fcsm_pkg::FCSM_OP_PROG ||
                   op == fcsm_pkg::FCSM_OP_FAST_PROG)
            state_reg <= FCSM_S_BUSY;
          else
            state_reg <= FCSM_S_IDLE;
        end
        FCSM_S_READ:
        begin
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_done(cnt_reg, fcsm_pkg::T_READ_CYC))
            state_reg <= FCSM_S_IDLE;
        end
        FCSM_S_BUSY:
        begin
          // No command goes out until the flash reports ready again or the busy timeout sends the host to FCSM_S_HRST.
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg > 16'h0001 && i_ready_busy_n)
            state_reg <= FCSM_S_IDLE;
          else if (cnt_done(cnt_reg, BUSY_TIMEOUT))
          begin
            cnt_reg <= 16'h0000;
            state_reg <= FCSM_S_HRST;
          end
        end
        FCSM_S_HRST:
        begin
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_done(cnt_reg, fcsm_pkg::T_HRST_CYC))
            state_reg <= FCSM_S_IDLE;
        end
      endcase
  end

  // ---------------------------------------------------------------
  // Pins
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_flash_addr <= '0;
      o_dq_out <= 16'h0000;
      o_dq_oe <= 1'b0;
      o_chip_enable_n <= 1'b1;
      o_write_enable_n <= 1'b1;
      o_output_enable_n <= 1'b1;
      o_byte_width_select_n <= 1'b1;
      o_hw_reset_n <= 1'b0;
    end
    else
    begin
      o_hw_reset_n <= state_reg != FCSM_S_HRST;
      o_byte_width_select_n <= !byte_mode;
      o_dq_oe <= state_reg == FCSM_S_SETUP || state_reg == FCSM_S_STROBE;
      o_write_enable_n <= !(state_reg == FCSM_S_SETUP ||
                            (state_reg == FCSM_S_STROBE &&
                             !cnt_done(cnt_reg, fcsm_pkg::T_STROBE_CYC)));
      o_chip_enable_n <= !(state_reg == FCSM_S_SETUP ||
                           (state_reg == FCSM_S_STROBE &&
                            !cnt_done(cnt_reg, fcsm_pkg::T_STROBE_CYC)) ||
                           (state_reg == FCSM_S_IDLE && rd_go) ||
                           (state_reg == FCSM_S_READ &&
                            !cnt_done(cnt_reg, fcsm_pkg::T_READ_CYC)));
      o_output_enable_n <= !((state_reg == FCSM_S_IDLE && rd_go) ||
                             (state_reg == FCSM_S_READ &&
                              !cnt_done(cnt_reg, fcsm_pkg::T_READ_CYC)));
      if (state_reg == FCSM_S_SETUP)
      begin
        o_flash_addr <= ADDR_W'(cyc.addr);
        o_dq_out <= cyc.data;
      end
      else if (state_reg == FCSM_S_IDLE && rd_go)
        o_flash_addr <= ADDR_W'(tgt_addr);
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      rdata_reg <= 16'h0000;
    else if (state_reg == FCSM_S_READ &&
             cnt_done(cnt_reg, fcsm_pkg::T_READ_CYC))
      rdata_reg <= i_dq_in;
  end

  // ---------------------------------------------------------------
  // Flash mode tracking
  // ---------------------------------------------------------------
  // Timeout flag is sampled from data bit 5 on reads outside identification mode; a reset command
  // clears it and the identification mode alike.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ident_reg <= 1'b0;
      fast_reg <= 1'b0;
      serial_reg <= 1'b0;
      timeout_reg <= 1'b0;
      err_reg <= 1'b0;
    end
    else
    begin
      if (state_reg == FCSM_S_READ && !ident_reg &&
          cnt_done(cnt_reg, fcsm_pkg::T_READ_CYC) && i_dq_in[5])
        timeout_reg <= 1'b1;
      else if (state_reg == FCSM_S_HOLD && idx_reg >= len)
        unique case (op)
          fcsm_pkg::FCSM_OP_RESET:
          begin
            ident_reg <= 1'b0;
            timeout_reg <= 1'b0;
          end
          fcsm_pkg::FCSM_OP_IDENT: ident_reg <= 1'b1;
          fcsm_pkg::FCSM_OP_SER_ENTER: serial_reg <= 1'b1;
          fcsm_pkg::FCSM_OP_SER_EXIT: serial_reg <= 1'b0;
          fcsm_pkg::FCSM_OP_FAST_ENTER: fast_reg <= 1'b1;
          fcsm_pkg::FCSM_OP_FAST_EXIT: fast_reg <= 1'b0;
          default:
          begin
          end
        endcase
      // Only fast program and fast exit are legal in fast mode.
      if (start && state_reg == FCSM_S_IDLE)
        err_reg <= fast_reg && op != fcsm_pkg::FCSM_OP_FAST_PROG &&
                   op != fcsm_pkg::FCSM_OP_FAST_EXIT;
      if (state_reg == FCSM_S_HRST)
      begin
        ident_reg <= 1'b0;
        fast_reg <= 1'b0;
        serial_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_WE_WITH_CE: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_write_enable_n |-> !o_chip_enable_n)
    else $error("Write strobe without chip enable.");
  AST_DATA_STABLE: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_write_enable_n |=> $stable(o_dq_out))
    else $error("Data moved during write strobe.");
  AST_NO_WR_BUSY: assert property (@(posedge i_clk) disable iff (i_rst)
    state_reg == FCSM_S_BUSY |-> o_write_enable_n)
    else $error("Write issued while flash busy.");
  AST_HRST_PIN: assert property (@(posedge i_clk) disable iff (i_rst)
    state_reg == FCSM_S_HRST |=> !o_hw_reset_n)
    else $error("Hardware reset not driven.");
  AST_IDENT_SET: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_reg == FCSM_S_HOLD && op == fcsm_pkg::FCSM_OP_IDENT &&
     idx_reg == 3'h3) |=> ident_reg)
    else $error("Identification mode not tracked.");
  AST_RESET_CLR: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_reg == FCSM_S_HOLD && op == fcsm_pkg::FCSM_OP_RESET)
    |=> !ident_reg)
    else $error("Reset left identification mode set.");
  AST_FAST_SET: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_reg == FCSM_S_HOLD && op == fcsm_pkg::FCSM_OP_FAST_ENTER &&
     idx_reg == 3'h3) |=> fast_reg)
    else $error("Fast mode not tracked.");
  AST_PROG_BUSY: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_reg == FCSM_S_HOLD && op == fcsm_pkg::FCSM_OP_PROG &&
     idx_reg == 3'h4) |=> state_reg == FCSM_S_BUSY)
    else $error("Program did not wait for completion.");

endmodule : fcsm_host
`default_nettype wire

// [src/fcsm_pkg.sv]
/*
  Constants, command codes and carrier types for the flash command host.
  Assumes a parallel NOR flash with an asynchronous write-cycle bus.
*/
// How it works
// - Host sends reset after timeout or identification; this host pulses hardware reset after busy timeout, none after identification
// - Two unlocks plus identify command enters mode
// - Three cycles enter, four exit serial region
// - Program is two unlocks, setup, address data
// - Two unlocks plus 20h enter fast mode
// - Fast program is A0h then address data
// - Fast exit is 90h then 00h
package fcsm_pkg;

  // ---------------------------------------------------------------
  // Command codes and offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_FAST_ENTER = 8'h20;
  localparam logic [7:0] CMD_FAST_PROG = 8'hA0;
  localparam logic [7:0] CMD_FAST_EXIT1 = 8'h90;
  localparam logic [7:0] CMD_FAST_EXIT2 = 8'h00;
  localparam logic [7:0] ID_OFS_MAKER = 8'h00;
  localparam logic [7:0] ID_OFS_DEV_W = 8'h01;
  localparam logic [7:0] ID_OFS_DEV_B = 8'h02;
  localparam logic [7:0] ID_OFS_PROT_W = 8'h02;
  localparam logic [7:0] ID_OFS_PROT_B = 8'h04;

  // ---------------------------------------------------------------
  // Host register map
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_DATA = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  localparam int CTRL_BYTE_BIT = 4;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Pin timing at 10 MHz
  // ---------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam int T_STROBE_NS = 100;
  localparam int T_STROBE_CYC = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_READ_NS = 200;
  localparam int T_READ_CYC = (T_READ_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_HRST_NS = 500;
  localparam int T_HRST_CYC = (T_HRST_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUSY_TIMEOUT_CYC = 40000;

  typedef enum logic [2:0] {
    FCSM_OP_RESET,
    FCSM_OP_IDENT,
    FCSM_OP_PROG,
    FCSM_OP_SER_ENTER,
    FCSM_OP_SER_EXIT,
    FCSM_OP_FAST_ENTER,
    FCSM_OP_FAST_PROG,
    FCSM_OP_FAST_EXIT
  } fcsm_op_t;

  typedef struct packed {
    logic [20:0] addr;
    logic [15:0] data;
  } fcsm_cycle_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } fcsm_req_t;

endpackage : fcsm_pkg

// [src/fcsm_seq_rom.sv]
/*
  Sequence table: bus cycles for each command sequence.
  Assumes the unlock addresses and codes are given by parameters.
*/
`timescale 1ns/10ps
`default_nettype none
module fcsm_seq_rom #(
  parameter logic [20:0] UNLOCK_A1 = 21'h000555,
  parameter logic [20:0] UNLOCK_A2 = 21'h0002AA,
  parameter logic [7:0] UNLOCK_D1 = 8'hAA,
  parameter logic [7:0] UNLOCK_D2 = 8'h55,
  parameter logic [7:0] CMD_RESET = 8'hF0,
  parameter logic [7:0] CMD_IDENT = 8'h90,
  parameter logic [7:0] CMD_PROG = 8'hA0,
  parameter logic [7:0] CMD_SER_ENTER = 8'h88,
  parameter logic [7:0] CMD_SER_EXIT = 8'h90
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire fcsm_pkg::fcsm_op_t i_op,
  input wire logic [2:0] i_idx,
  input wire logic [20:0] i_tgt_addr,
  input wire logic [15:0] i_tgt_data,
  output fcsm_pkg::fcsm_cycle_t o_cycle,
  output logic [2:0] o_len
);

  fcsm_pkg::fcsm_cycle_t cyc_next;
  logic [2:0] len_next;

  function automatic fcsm_pkg::fcsm_cycle_t mk(input logic [20:0] a,
                                               input logic [7:0] d);
    mk = '{addr: a, data: {8'h00, d}};
  endfunction : mk

  // ---------------------------------------------------------------
  // Cycle lookup
  // ---------------------------------------------------------------
  always_comb
  begin
    cyc_next = mk(UNLOCK_A1, UNLOCK_D1);
    len_next = 3'h3;
    if (i_idx == 3'h1)
      cyc_next = mk(UNLOCK_A2, UNLOCK_D2);
    unique case (i_op)
      fcsm_pkg::FCSM_OP_RESET:
      begin
        len_next = 3'h1;
        cyc_next = mk(i_tgt_addr, CMD_RESET);
      end
      fcsm_pkg::FCSM_OP_IDENT:
        if (i_idx == 3'h2) cyc_next = mk(UNLOCK_A1, CMD_IDENT);
      fcsm_pkg::FCSM_OP_PROG:
      begin
        len_next = 3'h4;
        if (i_idx == 3'h2) cyc_next = mk(UNLOCK_A1, CMD_PROG);
        if (i_idx == 3'h3) cyc_next = '{addr: i_tgt_addr, data: i_tgt_data};
      end
      fcsm_pkg::FCSM_OP_SER_ENTER:
        if (i_idx == 3'h2) cyc_next = mk(UNLOCK_A1, CMD_SER_ENTER);
      fcsm_pkg::FCSM_OP_SER_EXIT:
      begin
        len_next = 3'h4;
        if (i_idx == 3'h2) cyc_next = mk(UNLOCK_A1, CMD_SER_EXIT);
        if (i_idx == 3'h3) cyc_next = mk(21'h000000, 8'h00);
      end
      fcsm_pkg::FCSM_OP_FAST_ENTER:
        if (i_idx == 3'h2)
          cyc_next = mk(UNLOCK_A1, fcsm_pkg::CMD_FAST_ENTER);
      fcsm_pkg::FCSM_OP_FAST_PROG:
      begin
        len_next = 3'h2;
        if (i_idx == 3'h0)
          cyc_next = mk(21'h000000, fcsm_pkg::CMD_FAST_PROG);
        else
          cyc_next = '{addr: i_tgt_addr, data: i_tgt_data};
      end
      fcsm_pkg::FCSM_OP_FAST_EXIT:
      begin
        len_next = 3'h2;
        cyc_next = (i_idx == 3'h0) ? mk(21'h000000, fcsm_pkg::CMD_FAST_EXIT1)
                                   : mk(21'h000000, fcsm_pkg::CMD_FAST_EXIT2);
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_cycle <= '0;
      o_len <= 3'h0;
    end
    else
    begin
      o_cycle <= cyc_next;
      o_len <= len_next;
    end
  end

endmodule : fcsm_seq_rom
`default_nettype wire

// [src/fcsm_regs.sv]
/*
  Host register file for the flash command host.
  Assumes a single-clock master with one-cycle strobes.
*/
`timescale 1ns/10ps
`default_nettype none
module fcsm_regs (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire fcsm_pkg::fcsm_req_t i_req,
  input wire logic [31:0] i_status,
  input wire logic [15:0] i_rdata,
  output logic [31:0] o_rdata,
  output logic [20:0] o_addr,
  output logic [15:0] o_data,
  output logic o_byte_mode,
  output logic o_start,
  output logic [2:0] o_op,
  output logic o_read
);

  // ---------------------------------------------------------------
  // Writes: control starts a command, rdata starts a read, address and data hold operands
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_addr <= 21'h000000;
      o_data <= 16'h0000;
      o_byte_mode <= 1'b0;
      o_op <= 3'h0;
    end
    else if (i_req.wr)
    begin
      if (i_req.addr == fcsm_pkg::REG_ADDR) o_addr <= i_req.wdata[20:0];
      if (i_req.addr == fcsm_pkg::REG_DATA) o_data <= i_req.wdata[15:0];
      if (i_req.addr == fcsm_pkg::REG_CTRL)
      begin
        o_op <= i_req.wdata[2:0];
        o_byte_mode <= i_req.wdata[fcsm_pkg::CTRL_BYTE_BIT];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_start <= 1'b0;
      o_read <= 1'b0;
    end
    else
    begin
      o_start <= i_req.wr && i_req.addr == fcsm_pkg::REG_CTRL;
      o_read <= i_req.wr && i_req.addr == fcsm_pkg::REG_RDATA;
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_rdata <= 32'h0000_0000;
    else if (!i_req.rd)
      o_rdata <= 32'h0000_0000;
    else
      unique case (i_req.addr)
        fcsm_pkg::REG_CTRL: o_rdata <= {27'h0, o_byte_mode, 1'b0, o_op};
        fcsm_pkg::REG_ADDR: o_rdata <= {11'h0, o_addr};
        fcsm_pkg::REG_DATA: o_rdata <= {16'h0, o_data};
        fcsm_pkg::REG_STATUS: o_rdata <= i_status;
        fcsm_pkg::REG_RDATA: o_rdata <= {16'h0, i_rdata};
        default: o_rdata <= 32'h0000_0000;
      endcase
  end

endmodule : fcsm_regs
`default_nettype wire

// [tb/fcsm_flash_model.sv]
/*
  Behavioural model of the parallel NOR flash behind the command host.
  Assumes the host drives the enables, address and data lines directly.
*/
`timescale 1ns/10ps
`default_nettype none
module fcsm_flash_model #(
  parameter logic [15:0] MAKER_CODE = 16'h00C5, // Arbitrary value.
  parameter logic [15:0] DEVICE_CODE = 16'h2E7B, // Arbitrary value.
  parameter logic [5:0] PROT_SECTOR = 6'h3E,
  parameter logic [15:0] SERIAL_SEED = 16'h5E00,
  parameter logic [20:0] UNLOCK_A1 = 21'h000555,
  parameter logic [20:0] UNLOCK_A2 = 21'h0002AA
) (
  input wire logic [20:0] i_addr,
  input wire logic [15:0] i_dq,
  output logic [15:0] o_dq,
  input wire logic i_ce_n,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  input wire logic i_byte_n,
  input wire logic i_hw_reset_n,
  input wire logic [31:0] i_busy_ns,
  output logic o_ready_busy_n
);
  localparam logic [1:0] M_ARR = 2'h0;
  localparam logic [1:0] M_ID = 2'h1;
  localparam logic [1:0] M_FAST = 2'h2;
  localparam logic [1:0] M_SER = 2'h3;
  logic [15:0] mem [logic [20:0]];
  logic [1:0] mode;
  logic [2:0] ph;
  logic [20:0] a_lat;
  logic [15:0] val;
  logic [15:0] last;
  logic [7:0] ofs;
  logic tog;
  logic p7;
  wire wr_n = i_ce_n | i_we_n;
  wire drv = !i_ce_n && !i_oe_n && i_we_n && i_hw_reset_n;

  function automatic logic [15:0] rd_mem(input logic [20:0] a);
    rd_mem = mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction : rd_mem

  initial
  begin
    mode = M_ARR;
    ph = 3'h0;
    tog = 1'b0;
    p7 = 1'b0;
    last = 16'h0000;
    o_ready_busy_n = 1'b1;
  end

  // The host moves the address in the same step as the strobe fall.
  always @(negedge wr_n)
  begin
    #1;
    a_lat = i_addr;
  end

  always @(negedge i_hw_reset_n)
  begin
    mode = M_ARR;
    ph = 3'h0;
    o_ready_busy_n = 1'b1;
  end

  always @(negedge i_oe_n)
    if (!o_ready_busy_n)
      tog = ~tog;

  // Writes during an embedded program fall through untouched.
  always @(posedge wr_n)
  begin : take_write
    logic [7:0] d;
    d = i_dq[7:0];
    if (!o_ready_busy_n || !i_hw_reset_n)
      d = d;
    else if (ph == 3'h3)
    begin
      mem[a_lat] = rd_mem(a_lat) & i_dq;
      p7 = ~i_dq[7];
      ph = 3'h0;
      o_ready_busy_n = 1'b0;
      o_ready_busy_n <= #(i_busy_ns) 1'b1;
    end
    else if (mode == M_FAST && d == 8'hA0)
      ph = 3'h3;
    else if (mode == M_FAST && d == 8'h90)
      ph = 3'h5;
    else if (mode == M_FAST)
    begin
      mode = (ph == 3'h5 && d == 8'h00) ? M_ARR : M_FAST;
      ph = 3'h0;
    end
    else if (d == 8'hF0)
    begin
      mode = (mode == M_SER) ? M_SER : M_ARR;
      ph = 3'h0;
    end
    else if (ph == 3'h0 && a_lat == UNLOCK_A1 && d == 8'hAA)
      ph = 3'h1;
    else if (ph == 3'h1 && a_lat == UNLOCK_A2 && d == 8'h55)
      ph = 3'h2;
    else if (ph == 3'h2 && a_lat == UNLOCK_A1)
    begin
      ph = (d == 8'hA0) ? 3'h3 : 3'h0;
      if (d == 8'h90 && mode == M_SER)
        ph = 3'h6;
      else if (d == 8'h90)
        mode = M_ID;
      if (d == 8'h88)
        mode = M_SER;
      if (d == 8'h20)
        mode = M_FAST;
    end
    else if (ph == 3'h6 && d == 8'h00)
    begin
      mode = M_ARR;
      ph = 3'h0;
    end
    else
      ph = 3'h0;
  end

  always @(i_addr or i_oe_n or mode or o_ready_busy_n or tog)
  begin
    ofs = i_byte_n ? i_addr[7:0] : {1'b0, i_addr[7:1]};
    if (!o_ready_busy_n)
      val = {8'h00, p7, tog, 6'h00};
    else if (mode == M_ID && ofs == 8'h00)
      val = MAKER_CODE;
    else if (mode == M_ID && ofs == 8'h01)
      val = DEVICE_CODE;
    else if (mode == M_ID)
      val = {15'h0000, i_addr[20:15] == PROT_SECTOR};
    else if (mode == M_SER)
      val = SERIAL_SEED | {12'h000, i_addr[3:0]};
    else
      val = rd_mem(i_addr);
  end

  // A released bus shows the inverse of its last value, never a hold.
  always @(val or drv)
    if (drv)
      last = val;
  assign o_dq = drv ? val : ~last;
endmodule : fcsm_flash_model
`default_nettype wire

// [tb/tb.sv]
/*
  Self-checking bench for the flash command host with a flash model.
  Assumes the register map and timing given in the host package.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic i_clk, i_rst, i_wr, i_rd;
  logic [3:0] i_addr;
  logic [31:0] i_wdata, o_rdata, busy_ns;
  logic [20:0] fa;
  logic [15:0] host_dq, flash_dq;
  logic dq_oe, ce_n, we_n, oe_n, byte_n, hrst_n, rb_n;
  int bad_count, n_checks, cyc, hrst_falls;
  wire [15:0] dq = dq_oe ? host_dq : flash_dq;

  fcsm_host #(.BUSY_TIMEOUT(50)) i_fcsm_host (.i_clk(i_clk),
    .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_flash_addr(fa),
    .o_dq_out(host_dq), .o_dq_oe(dq_oe), .i_dq_in(dq),
    .o_chip_enable_n(ce_n), .o_write_enable_n(we_n),
    .o_output_enable_n(oe_n), .o_byte_width_select_n(byte_n),
    .o_hw_reset_n(hrst_n), .i_ready_busy_n(rb_n));
  fcsm_flash_model i_fcsm_flash_model (.i_addr(fa), .i_dq(dq),
    .o_dq(flash_dq), .i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n),
    .i_byte_n(byte_n), .i_hw_reset_n(hrst_n), .i_busy_ns(busy_ns),
    .o_ready_busy_n(rb_n));

  always #50 i_clk = ~i_clk;
  always @(negedge hrst_n)
    if (!i_rst)
      hrst_falls++;
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      tally_and_finish;
    end
  end

  task tally_and_finish;
    if (bad_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : reg_wr

  task reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : reg_rd

  task wait_idle;
    logic [31:0] s;
    int n;
    n = 0;
    repeat (2) @(posedge i_clk);
    reg_rd(fcsm_pkg::REG_STATUS, s);
    while (s[1] !== 1'b0 && n < 400)
    begin
      reg_rd(fcsm_pkg::REG_STATUS, s);
      n++;
    end
    chk({31'h0, s[1]}, 32'h0);
  endtask : wait_idle

  task start_op(input logic [2:0] op, input logic [20:0] a,
    input logic [15:0] d);
    reg_wr(fcsm_pkg::REG_ADDR, {11'h000, a});
    reg_wr(fcsm_pkg::REG_DATA, {16'h0000, d});
    reg_wr(fcsm_pkg::REG_CTRL, {29'h0, op});
  endtask : start_op

  task run_op(input logic [2:0] op, input logic [20:0] a,
    input logic [15:0] d);
    start_op(op, a, d);
    wait_idle;
  endtask : run_op

  task rdx(input logic [20:0] a, input logic [31:0] exp);
    logic [31:0] s;
    reg_wr(fcsm_pkg::REG_ADDR, {11'h000, a});
    reg_wr(fcsm_pkg::REG_RDATA, 32'h0);
    wait_idle;
    reg_rd(fcsm_pkg::REG_RDATA, s);
    chk(s, exp);
  endtask : rdx

  task t_reset;
    logic [31:0] s;
    reg_rd(fcsm_pkg::REG_STATUS, s);
    chk(s, fcsm_pkg::STATUS_RESET);
    reg_rd(4'hF, s);
    chk(s, 32'h0);
    chk({29'h0, ce_n, we_n, oe_n}, 32'h7);
    rdx(21'h000100, 32'hFFFF);
  endtask : t_reset

  task t_prog;
    run_op(fcsm_pkg::FCSM_OP_PROG, 21'h000100, 16'h00FF);
    run_op(fcsm_pkg::FCSM_OP_PROG, 21'h1F0000, 16'h1234);
    run_op(fcsm_pkg::FCSM_OP_PROG, 21'h000100, 16'hFF00);
    rdx(21'h000100, 32'h0000);
    rdx(21'h1F0000, 32'h1234);
  endtask : t_prog

  task t_ident;
    logic [31:0] s;
    run_op(fcsm_pkg::FCSM_OP_IDENT, 21'h0, 16'h0);
    rdx(21'h000000, 32'h00C5);
    rdx(21'h000001, 32'h2E7B);
    rdx(21'h1F0002, 32'h1);
    rdx(21'h008002, 32'h0);
    rdx(21'h000000, 32'h00C5);
    reg_rd(fcsm_pkg::REG_STATUS, s);
    chk({31'h0, s[3]}, 32'h1);
    run_op(fcsm_pkg::FCSM_OP_RESET, 21'h1ABCDE, 16'h0);
    rdx(21'h000100, 32'h0000);
  endtask : t_ident

  task t_serial;
    run_op(fcsm_pkg::FCSM_OP_SER_ENTER, 21'h0, 16'h0);
    rdx(21'h000005, 32'h5E05);
    run_op(fcsm_pkg::FCSM_OP_SER_EXIT, 21'h0, 16'h0);
    rdx(21'h000100, 32'h0000);
  endtask : t_serial

  task t_fast;
    logic [31:0] s;
    run_op(fcsm_pkg::FCSM_OP_FAST_ENTER, 21'h0, 16'h0);
    run_op(fcsm_pkg::FCSM_OP_FAST_PROG, 21'h000200, 16'h5AA5);
    run_op(fcsm_pkg::FCSM_OP_FAST_PROG, 21'h000201, 16'h0F0F);
    run_op(fcsm_pkg::FCSM_OP_IDENT, 21'h0, 16'h0);
    reg_rd(fcsm_pkg::REG_STATUS, s);
    chk({30'h0, s[7], s[4]}, 32'h3);
    run_op(fcsm_pkg::FCSM_OP_FAST_EXIT, 21'h0, 16'h0);
    rdx(21'h000200, 32'h5AA5);
    rdx(21'h000201, 32'h0F0F);
    reg_rd(fcsm_pkg::REG_STATUS, s);
    chk({31'h0, s[4]}, 32'h0);
  endtask : t_fast

  task t_slow;
    logic [31:0] s;
    busy_ns = 32'd3000;
    start_op(fcsm_pkg::FCSM_OP_PROG, 21'h000300, 16'h1111);
    repeat (25) @(posedge i_clk);
    reg_rd(fcsm_pkg::REG_STATUS, s);
    chk({30'h0, s[2:1]}, 32'h3);
    wait_idle;
    rdx(21'h000300, 32'h1111);
  endtask : t_slow

  task t_tmo;
    int n;
    busy_ns = 32'd20000;
    n = hrst_falls;
    run_op(fcsm_pkg::FCSM_OP_PROG, 21'h000400, 16'h2222);
    chk(32'(hrst_falls - n), 32'h1);
    busy_ns = 32'd200;
    rdx(21'h000100, 32'h0000);
  endtask : t_tmo

  initial
  begin
    i_clk = 1'b0;
    i_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 4'h0;
    i_wdata = 32'h0;
    busy_ns = 32'd200;
    bad_count = 0;
    n_checks = 0;
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (8) @(posedge i_clk);
    t_reset;
    t_prog;
    t_ident;
    t_serial;
    t_fast;
    t_slow;
    t_tmo;
    tally_and_finish;
  end
endmodule : tb
`default_nettype wire
